// >>> src/dual_channel_serial_interface.sv
`timescale 1ns/1ps
`include "serial_regs.svh"


module dual_channel_serial_interface #(
  parameter int ADDR_W = 8,
  parameter int NPINS  = 5
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NPINS-1:0]  pin_in,
  output logic      [NPINS-1:0]  pin_out,
  output logic      [NPINS-1:0]  pin_oe_n
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  serial_pkg::nibble_t   mode_reg;
  serial_pkg::nibble_t   freq_reg;
  serial_pkg::nibble_t   wait_reg;
  serial_pkg::channel_t  chan;
  serial_pkg::protocol_t prot;
  logic [NPINS-1:0]      dir_reg;
  logic [NPINS-1:0]      port_reg;
  logic [NPINS-1:0]      pin_lvl;
  logic [NPINS-1:0]      pin_rise;
  logic [NPINS-1:0]      pin_fall;
  logic [NPINS-1:0]      pin_drv;
  logic [NPINS-1:0]      pin_val;
  logic [7:0]            shift_reg;
  logic [3:0]            cnt_reg;
  logic [3:0]            cnt_next;
  logic [7:0]            div_reg;
  logic [7:0]            half_cyc;
  logic                  gen_clk_reg;
  logic                  gen_rise;
  logic                  gen_fall;
  logic                  sh_rise;
  logic                  sh_fall;
  logic                  din;
  logic                  dout_reg;
  logic                  ack_slot_reg;
  logic                  busy_reg;
  logic                  stt_reg;
  logic                  nine_reg;
  logic                  eight_reg;
  logic                  start_det;
  logic                  stop_det;
  logic                  cnt_clr;
  logic                  wr_en;
  logic                  rd_en;
  logic                  mode_wr;
  logic                  wait_wr;
  logic                  tx_bit;
  logic                  clk_int;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [5:0] idx);
    reg_hit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // ----------------------------------------
  // Mode fields
  // ----------------------------------------
  assign chan    = serial_pkg::channel_t'(mode_reg[`MODE_CH_BIT]);
  assign prot    = serial_pkg::protocol_t'(mode_reg[`MODE_PROT_BIT]);
  assign clk_int = mode_reg[`MODE_CLK_BIT];
  assign tx_bit  = mode_reg[`MODE_TX_BIT];

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  pin_sync #(
    .WIDTH (NPINS)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_in    (pin_in),
    .level   (pin_lvl),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign mode_wr = wr_en && reg_hit(paddr, `MODE_IDX);
  assign wait_wr = wr_en && reg_hit(paddr, `WAIT_IDX);

  always_comb begin
    pslverr = 1'b0;
    if (!(psel && penable)) begin
      pslverr = 1'b0;
    end else if (reg_hit(paddr, `MODE_IDX) ||
                 reg_hit(paddr, `STATUS_IDX) ||
                 reg_hit(paddr, `FREQ_IDX) ||
                 reg_hit(paddr, `WAIT_IDX) ||
                 reg_hit(paddr, `PORT_DIR_IDX) ||
                 reg_hit(paddr, `PORT_OUT_IDX) ||
                 reg_hit(paddr, `SHIFT_IDX) ||
                 reg_hit(paddr, `PIN_IN_IDX)) begin
      pslverr = 1'b0;
    end else begin
      pslverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (reg_hit(paddr, `MODE_IDX)) begin
        prdata <= {28'h000_0000, mode_reg};
      end else if (reg_hit(paddr, `STATUS_IDX)) begin
        prdata <= {28'h000_0000, eight_reg, nine_reg, stt_reg, busy_reg};
      end else if (reg_hit(paddr, `FREQ_IDX)) begin
        prdata <= {28'h000_0000, freq_reg};
      end else if (reg_hit(paddr, `WAIT_IDX)) begin
        prdata <= {28'h000_0000, wait_reg};
      end else if (reg_hit(paddr, `PORT_DIR_IDX)) begin
        prdata <= {27'h000_0000, dir_reg};
      end else if (reg_hit(paddr, `PORT_OUT_IDX)) begin
        prdata <= {27'h000_0000, port_reg};
      end else if (reg_hit(paddr, `SHIFT_IDX)) begin
        prdata <= {24'h00_0000, shift_reg};
      end else if (reg_hit(paddr, `PIN_IN_IDX)) begin
        prdata <= {27'h000_0000, pin_lvl};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= `MODE_RESET;
    end else if (mode_wr) begin
      mode_reg <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_reg <= `FREQ_RESET;
      dir_reg  <= '0;
      port_reg <= '0;
    end else if (wr_en) begin
      if (reg_hit(paddr, `FREQ_IDX)) begin
        freq_reg <= pwdata[3:0];
      end else if (reg_hit(paddr, `PORT_DIR_IDX)) begin
        dir_reg <= pwdata[NPINS-1:0];
      end else if (reg_hit(paddr, `PORT_OUT_IDX)) begin
        port_reg <= pwdata[NPINS-1:0];
      end
    end
  end

  // Acknowledge bit: written by software in any mode, captured in bus transmit; capture wins in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= `WAIT_RESET;
    end else begin
      if (wait_wr) begin
        wait_reg <= pwdata[3:0];
      end
      if (sh_rise && cnt_reg == 4'h8 && prot == serial_pkg::PROT_BUS &&
          tx_bit) begin
        wait_reg[`WAIT_ACK_BIT] <= din;
      end
    end
  end

  // ----------------------------------------
  // Internal shift clock generator
  // ----------------------------------------
  assign half_cyc = 8'((({4'h0, freq_reg} + 8'h01) * `SCLK_UNIT_CYC));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg     <= 8'h00;
      gen_clk_reg <= 1'b1;
    end else if (!clk_int) begin
      div_reg     <= 8'h00;
      gen_clk_reg <= 1'b1;
    end else if (div_reg >= half_cyc - 8'h01) begin
      div_reg     <= 8'h00;
      gen_clk_reg <= ~gen_clk_reg;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  assign gen_rise = clk_int && !gen_clk_reg &&
                    (div_reg >= half_cyc - 8'h01);
  assign gen_fall = clk_int && gen_clk_reg &&
                    (div_reg >= half_cyc - 8'h01);

  // ----------------------------------------
  // Shared engine: clock and data select
  // ----------------------------------------
  always_comb begin
    if (chan == serial_pkg::CH_ZERO) begin
      din     = pin_lvl[`PIN_SDA];
      sh_rise = clk_int ? gen_rise : pin_rise[`PIN_SCL];
      sh_fall = clk_int ? gen_fall : pin_fall[`PIN_SCL];
    end else begin
      din     = pin_lvl[`PIN_SI];
      sh_rise = clk_int ? gen_rise : pin_rise[`PIN_SCK];
      sh_fall = clk_int ? gen_fall : pin_fall[`PIN_SCK];
    end
  end

  // Start and stop seen on channel zero only, no arbitration
  assign start_det = (chan == serial_pkg::CH_ZERO) &&
                     (prot == serial_pkg::PROT_BUS) &&
                     pin_lvl[`PIN_SCL] && pin_fall[`PIN_SDA];
  assign stop_det  = (chan == serial_pkg::CH_ZERO) &&
                     (prot == serial_pkg::PROT_BUS) &&
                     pin_lvl[`PIN_SCL] && pin_rise[`PIN_SDA];

  // ----------------------------------------
  // Clock counter
  // ----------------------------------------
  assign cnt_clr = (mode_wr &&
                    pwdata[`MODE_PROT_BIT] != mode_reg[`MODE_PROT_BIT]) ||
                   (prot == serial_pkg::PROT_BUS && start_det) ||
                   (prot == serial_pkg::PROT_SIO && wait_wr);

  always_comb begin
    if (cnt_clr) begin
      cnt_next = 4'h0;
    end else if (sh_rise) begin
      cnt_next = (cnt_reg == 4'h9) ? 4'h1 : cnt_reg + 4'h1;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // ----------------------------------------
  // Shift register and data out
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= 8'h00;
    end else if (wr_en && reg_hit(paddr, `SHIFT_IDX)) begin
      shift_reg <= pwdata[7:0];
    end else if (sh_rise && cnt_reg < 4'h8) begin
      shift_reg <= {shift_reg[6:0], din};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_reg     <= 1'b1;
      ack_slot_reg <= 1'b0;
    end else if (sh_fall) begin
      ack_slot_reg <= (cnt_reg == 4'h8);
      if (cnt_reg == 4'h8) begin
        dout_reg <= tx_bit ? 1'b1 : wait_reg[`WAIT_ACK_BIT];
      end else begin
        dout_reg <= shift_reg[7];
      end
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
    end else if (prot == serial_pkg::PROT_SIO) begin
      busy_reg <= 1'b0;
    end else if (start_det) begin
      busy_reg <= 1'b1;
    end else if (stop_det) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stt_reg <= 1'b0;
    end else if (start_det) begin
      stt_reg <= 1'b1;
    end else if (cnt_reg == 4'h9) begin
      stt_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nine_reg  <= 1'b0;
      eight_reg <= 1'b0;
    end else begin
      if (cnt_next == 4'h9) begin
        nine_reg <= 1'b1;
      end else if (cnt_next <= 4'h1) begin
        nine_reg <= 1'b0;
      end
      if (cnt_next == 4'h8) begin
        eight_reg <= 1'b1;
      end else if (cnt_next <= 4'h1) begin
        eight_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  always_comb begin
    pin_drv = dir_reg;
    pin_val = port_reg;
    if (chan == serial_pkg::CH_ZERO) begin
      if (tx_bit && !(prot == serial_pkg::PROT_BUS && ack_slot_reg)) begin
        pin_drv[`PIN_SDA] = (prot == serial_pkg::PROT_SIO) || !dout_reg;
        pin_val[`PIN_SDA] = dout_reg;
      end else if (tx_bit) begin
        pin_drv[`PIN_SDA] = 1'b0;
      end else if (prot == serial_pkg::PROT_BUS && ack_slot_reg) begin
        pin_drv[`PIN_SDA] = !dout_reg;
        pin_val[`PIN_SDA] = dout_reg;
      end
      if (clk_int) begin
        pin_drv[`PIN_SCL] = (prot == serial_pkg::PROT_SIO) || !gen_clk_reg;
        pin_val[`PIN_SCL] = gen_clk_reg;
      end
    end else begin
      if (clk_int) begin
        pin_drv[`PIN_SCK] = 1'b1;
        pin_val[`PIN_SCK] = gen_clk_reg;
      end
      if (tx_bit) begin
        pin_drv[`PIN_SO] = 1'b1;
        pin_val[`PIN_SO] = dout_reg;
      end
    end
  end

  assign pin_out  = pin_val;
  assign pin_oe_n = ~pin_drv;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_cnt_wrap: assert property (cnt_reg == 4'h9 && sh_rise && !cnt_clr
    |=> cnt_reg == 4'h1) else $error("counter did not wrap to 1");
  a_cnt_range: assert property (cnt_reg <= 4'h9)
    else $error("counter out of range");
  a_start_clr: assert property (start_det && prot == serial_pkg::PROT_BUS
    |=> cnt_reg == 4'h0 && busy_reg && stt_reg)
    else $error("start did not clear counter");
  a_wait_clr: assert property (wait_wr && prot == serial_pkg::PROT_SIO
    |=> cnt_reg == 4'h0) else $error("wait write kept count");
  a_busy_sio: assert property (prot == serial_pkg::PROT_SIO |=> !busy_reg)
    else $error("busy set in serial mode");
  a_busy_stop: assert property (stop_det && !start_det |=> !busy_reg)
    else $error("busy kept after stop");
  a_stt_nine: assert property (cnt_reg == 4'h9 && !start_det |=> !stt_reg)
    else $error("start flag kept at nine");
  a_nine_flag: assert property (nine_reg == (cnt_reg == 4'h9))
    else $error("nine flag mismatch");
  a_eight_flag: assert property (eight_reg == (cnt_reg >= 4'h8))
    else $error("eight flag mismatch");
  a_status_ro: assert property (wr_en && reg_hit(paddr, `STATUS_IDX) &&
    !sh_rise && !start_det && !stop_det && !cnt_clr && prot ==
    serial_pkg::PROT_BUS |=> $stable({eight_reg, nine_reg, busy_reg}))
    else $error("status changed by write");
  a_free_pins: assert property (chan == serial_pkg::CH_ONE
    |-> pin_oe_n[1:0] == ~dir_reg[1:0])
    else $error("unselected pins not ports");

  c_start: cover property (start_det ##[1:400] stop_det);
  c_nine: cover property (cnt_reg == 4'h9 ##[1:1000] cnt_reg == 4'h1);
  c_ch1_int: cover property (chan == serial_pkg::CH_ONE && gen_rise);
  c_ack: cover property (ack_slot_reg && prot == serial_pkg::PROT_BUS);

endmodule

// >>> src/pin_sync.sv
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] last_reg;

  // ----------------------------------------
  // Two-stage synchroniser and edge history
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '1;
      sync_reg <= '1;
      last_reg <= '1;
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~last_reg;
  assign fall  = ~sync_reg & last_reg;

endmodule

// >>> src/serial_pkg.sv
package serial_pkg;

  typedef logic [3:0] nibble_t;

  typedef enum logic [0:0] {
    CH_ZERO = 1'b0,
    CH_ONE  = 1'b1
  } channel_t;

  typedef enum logic [0:0] {
    PROT_SIO = 1'b0,
    PROT_BUS = 1'b1
  } protocol_t;

endpackage

// >>> src/serial_regs.svh
`ifndef SERIAL_REGS_SVH
`define SERIAL_REGS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define MODE_IDX      6'h08
`define STATUS_IDX    6'h28
`define FREQ_IDX      6'h39
`define WAIT_IDX      6'h3A
`define PORT_DIR_IDX  6'h3B
`define PORT_OUT_IDX  6'h3C
`define SHIFT_IDX     6'h3D
`define PIN_IN_IDX    6'h3E

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define MODE_TX_BIT   0
`define MODE_CLK_BIT  1
`define MODE_PROT_BIT 2
`define MODE_CH_BIT   3

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define STAT_BUSY_BIT 0
`define STAT_STT_BIT  1
`define STAT_NINE_BIT 2
`define STAT_EIGHT_BIT 3

// ----------------------------------------
// Wait register fields
// ----------------------------------------
`define WAIT_RUN_BIT  2
`define WAIT_ACK_BIT  3

// ----------------------------------------
// Pin indices
// ----------------------------------------
`define PIN_SDA 0
`define PIN_SCL 1
`define PIN_SCK 2
`define PIN_SO  3
`define PIN_SI  4

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define MODE_RESET    4'h0
`define FREQ_RESET    4'h0
`define WAIT_RESET    4'h0
`define CLK_PERIOD_NS 10
`define SCLK_UNIT_NS  80
`define SCLK_UNIT_CYC (`SCLK_UNIT_NS / `CLK_PERIOD_NS)

`endif

// >>> verif/serial_peer.sv
`timescale 1ns/1ps

module serial_peer (
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe_n,
  output logic      [4:0] pin_in
);
  logic [4:0] drv;
  logic [4:0] en;

  initial begin
    drv = 5'h1F;
    en  = 5'h00;
  end

  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  // SDA/SCL pulled high, others show inverse of last value when released
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (i < 2)
        pin_in[i] = (pin_oe_n[i] ? 1'b1 : pin_out[i])
                    & (en[i] ? drv[i] : 1'b1);
      else
        pin_in[i] = !pin_oe_n[i] ? pin_out[i]
                    : (en[i] ? drv[i] : ~drv[i]);
    end
  end

  // ----------------------------------------
  // Frames
  // ----------------------------------------
  // Clock burst, data on SDA changes only while clock low
  task automatic xfer(input int ck, input int n, input logic [7:0] d,
                      output logic [7:0] q);
    en[ck] = 1'b1;
    en[0]  = 1'b1;
    q      = 8'h00;
    for (int i = 0; i < n; i++) begin
      drv[ck] = 1'b0;
      #20;
      drv[0] = d[7 - (i % 8)];
      #60;
      q = {q[6:0], pin_in[0]};
      drv[ck] = 1'b1;
      #80;
    end
  endtask

  // Data falls while clock high
  task automatic start();
    en[1:0]  = 2'b11;
    drv[1:0] = 2'b11;
    #80;
    drv[0] = 1'b0;
    #80;
  endtask

  // Data rises while clock high
  task automatic stop();
    drv[1] = 1'b0;
    #40;
    drv[0] = 1'b0;
    #40;
    drv[1] = 1'b1;
    #80;
    drv[0] = 1'b1;
    #80;
  endtask

  task automatic release_all();
    en = 5'h00;
  endtask
endmodule

// >>> verif/tb_dual_channel_serial_interface.sv
`timescale 1ns/1ps
`include "serial_regs.svh"

module tb_dual_channel_serial_interface;
  typedef struct {
    logic [32:0] v;
    logic [32:0] m;
  } note_t;

  localparam logic [7:0]  addr_mode  = {`MODE_IDX, 2'b00};
  localparam logic [7:0]  addr_stat  = {`STATUS_IDX, 2'b00};
  localparam logic [7:0]  addr_freq  = {`FREQ_IDX, 2'b00};
  localparam logic [7:0]  addr_wait  = {`WAIT_IDX, 2'b00};
  localparam logic [7:0]  addr_dir   = {`PORT_DIR_IDX, 2'b00};
  localparam logic [7:0]  addr_out   = {`PORT_OUT_IDX, 2'b00};
  localparam logic [7:0]  addr_shift = {`SHIFT_IDX, 2'b00};
  localparam logic [32:0] all_m      = {33{1'b1}};

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  pin_in;
  logic [4:0]  pin_out;
  logic [4:0]  pin_oe_n;
  int          num_errors;
  int          tests_run;
  int          cnt;
  note_t       rdq[$];
  note_t       head;
  logic [31:0] lfsr_state;
  logic [31:0] d;
  logic [7:0]  q;

  dual_channel_serial_interface dual_channel_serial_interface_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n)
  );

  serial_peer serial_peer_inst (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic tally_and_finish();
    if (rdq.size() != 0)
      num_errors++;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
      if (i == 49) begin
        num_errors++;
        tally_and_finish();
      end
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e,
                    input logic [32:0] m);
    rdq.push_back('{v: e, m: m});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic rds(input logic [3:0] e);
    rd(addr_stat, {29'h0, e}, all_m);
  endtask

  // Read results compared against oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (rdq.size() == 0)
        check(33'h0, all_m);
      else begin
        head = rdq.pop_front();
        check({pslverr, prdata} & head.m, head.v & head.m);
      end
    end
  end

  initial begin
    #900000;
    num_errors++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    num_errors = 0;
    tests_run  = 0;
    lfsr_state = 32'h58CE;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(addr_mode, 33'h0, all_m);
    rds(4'h0);
    rd(8'h04, 33'h1_0000_0000, all_m);
    wr(addr_stat, 32'hF);
    rds(4'h0);
    for (int i = 0; i < 6; i++) begin
      lfsr_state = lfsr(lfsr_state);
      d = lfsr_state;
      if (d[3])
        d[2] = 1'b0;
      wr(addr_mode, d);
      rd(addr_mode, {29'h0, d[3:0]}, all_m);
    end
    // Channel zero counting
    wr(addr_dir, 32'h0);
    wr(addr_mode, 32'h0);
    wr(addr_wait, 32'h4);
    serial_peer_inst.xfer(1, 7, 8'hFF, q);
    rds(4'h0);
    serial_peer_inst.xfer(1, 1, 8'hFF, q);
    rds(4'h8);
    serial_peer_inst.xfer(1, 1, 8'hFF, q);
    rds(4'hC);
    serial_peer_inst.xfer(1, 1, 8'hFF, q);
    rds(4'h0);
    wr(addr_wait, 32'h4);
    serial_peer_inst.xfer(1, 8, 8'hFF, q);
    rds(4'h8);
    // Shift in and out
    lfsr_state = lfsr(lfsr_state);
    wr(addr_wait, 32'h4);
    serial_peer_inst.xfer(1, 8, lfsr_state[7:0], q);
    rd(addr_shift, {25'h0, lfsr_state[7:0]}, all_m);
    check({32'h0, pin_oe_n[0]}, 33'h1);
    wr(addr_mode, 32'h1);
    #1;
    check({32'h0, pin_oe_n[0]}, 33'h0);
    lfsr_state = lfsr(lfsr_state);
    wr(addr_wait, 32'h4);
    wr(addr_shift, lfsr_state);
    serial_peer_inst.xfer(1, 8, 8'hFF, q);
    check({25'h0, q}, {25'h0, lfsr_state[7:0]});
    // Channel one
    wr(addr_mode, 32'h8);
    wr(addr_wait, 32'h4);
    serial_peer_inst.xfer(1, 9, 8'hFF, q);
    rds(4'h0);
    serial_peer_inst.xfer(2, 8, 8'hFF, q);
    rds(4'h8);
    check({32'h0, pin_oe_n[3]}, 33'h1);
    wr(addr_dir, 32'h1);
    wr(addr_out, 32'h1);
    #1;
    check({31'h0, pin_oe_n[0], pin_out[0]}, 33'h1);
    wr(addr_mode, 32'h9);
    #1;
    check({32'h0, pin_oe_n[3]}, 33'h0);
    // Clock pin as software port
    wr(addr_dir, 32'h2);
    wr(addr_mode, 32'h0);
    for (int v = 0; v < 2; v++) begin
      wr(addr_out, {30'h0, v[0], 1'b0});
      #1;
      check({31'h0, pin_oe_n[1], pin_out[1]}, {32'h0, v[0]});
    end
    // Two-wire bus slave receive
    wr(addr_dir, 32'h0);
    wr(addr_mode, 32'h4);
    serial_peer_inst.start();
    rds(4'h3);
    serial_peer_inst.xfer(1, 8, 8'h00, q);
    rds(4'hB);
    serial_peer_inst.xfer(1, 1, 8'h00, q);
    rds(4'hD);
    serial_peer_inst.stop();
    rds(4'h0);
    serial_peer_inst.xfer(1, 7, 8'hFF, q);
    rds(4'h8);
    serial_peer_inst.start();
    rds(4'h3);
    wr(addr_mode, 32'h0);
    rd(addr_stat, 33'h0, 33'hD);
    // Two-wire bus slave transmit, acknowledge read after nine
    wr(addr_wait, 32'h0);
    wr(addr_mode, 32'h5);
    lfsr_state = lfsr(lfsr_state);
    wr(addr_shift, lfsr_state);
    serial_peer_inst.xfer(1, 8, 8'hFF, q);
    check({25'h0, q}, {25'h0, lfsr_state[7:0]});
    serial_peer_inst.xfer(1, 1, 8'hFF, q);
    rds(4'hC);
    rd(addr_wait, 33'h8, all_m);
    // Internal clock rate
    serial_peer_inst.release_all();
    for (int f = 0; f < 3; f += 2) begin
      wr(addr_freq, f);
      wr(addr_mode, 32'h2);
      wr(addr_wait, 32'h4);
      for (int i = 0; i < 400 && pin_in[1] !== 1'b0; i++)
        @(negedge pclk);
      cnt = 0;
      while (pin_in[1] === 1'b0 && cnt < 400) begin
        @(negedge pclk);
        cnt++;
      end
      check(33'(cnt), 33'((f + 1) * `SCLK_UNIT_CYC));
      wr(addr_mode, 32'h0);
    end
    repeat (5) @(posedge pclk);
    tally_and_finish();
  end
endmodule
